/* src/node_mode_flag_controller.sv */
`timescale 1ns/1ps
module node_mode_flag_controller (
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_n_i,
    input  wire node_mode_pkg::pin_in_t   pins_i,
    output node_mode_pkg::mode_t          mode_o,
    output logic                          wake_flag_o,
    output node_mode_pkg::uv_flags_t      uv_flags_o,
    output logic                          rx_data_o,
    output logic                          rx_active_n_o,
    output logic                          inhibit_out_a_o,
    output logic                          inhibit_out_a_oe_o,
    output logic                          inhibit_out_b_o,
    output logic                          inhibit_out_b_oe_o,
    output logic                          bus_plus_o,
    output logic                          bus_minus_o,
    output logic                          bus_drive_en_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic low_power(input node_mode_pkg::mode_t m);
        return (m == node_mode_pkg::MODE_STANDBY) || (m == node_mode_pkg::MODE_GO_SLEEP) ||
               (m == node_mode_pkg::MODE_SLEEP);
    endfunction

    // ----------------------------------------------------------------
    // synchronisation and edges
    // ----------------------------------------------------------------
    node_mode_pkg::pin_in_t   pin_s;
    node_mode_pkg::pin_in_t   pin_prev;
    logic [1:0]               accepted_pins;
    logic [1:0]               next_accepted_pins;
    logic                     pins_stable;
    logic                     pins_changed;
    logic                     hold_done;

    pin_sync #(
        .WIDTH ($bits(node_mode_pkg::pin_in_t))
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .async_i   (pins_i),
        .sync_o    (pin_s)
    );

    // previous synced levels for edge detection
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_s;
        end
    end

    assign pins_changed = (pin_s.standby_ctrl_n != pin_prev.standby_ctrl_n) ||
                          (pin_s.mode_sel != pin_prev.mode_sel);

    // control pins must be steady for the detection time
    mode_timer #(
        .TERMINAL (node_mode_pkg::MODE_PIN_DETECT_CYCLES)
    ) u_pin_timer (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .restart_i (pins_changed),
        .done_o    (pins_stable)
    );

    // go-to-sleep hold, running only with the wake flag clear
    node_mode_pkg::mode_t     mode;
    logic                     wake;
    node_mode_pkg::uv_flags_t uv;

    mode_timer #(
        .TERMINAL (node_mode_pkg::SLEEP_HOLD_CYCLES)
    ) u_hold_timer (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .restart_i ((mode != node_mode_pkg::MODE_GO_SLEEP) || wake),
        .done_o    (hold_done)
    );

    always_comb begin
        next_accepted_pins = accepted_pins;
        if (pins_stable) begin
            next_accepted_pins = {pin_s.standby_ctrl_n, pin_s.mode_sel};
        end
    end

    // ----------------------------------------------------------------
    // events
    // ----------------------------------------------------------------
    logic standby_ctrl_n_rise;
    logic io_rise;
    logic bat_rise;
    logic core_rise;
    logic uv_det;
    logic io_recover;
    logic bat_recover;
    logic core_recover;
    logic wake_set;
    logic wake_rise;
    node_mode_pkg::mode_t pin_mode;

    assign standby_ctrl_n_rise    = pin_s.standby_ctrl_n && !pin_prev.standby_ctrl_n;
    assign io_rise      = pin_s.io_supply_low && !pin_prev.io_supply_low;
    assign bat_rise     = pin_s.battery_low && !pin_prev.battery_low;
    assign core_rise    = pin_s.core_supply_low && !pin_prev.core_supply_low;
    assign uv_det       = io_rise || bat_rise || core_rise;
    assign io_recover   = uv.io_supply_low_flag && !pin_s.io_supply_low;
    assign bat_recover  = uv.battery_low_flag && !pin_s.battery_low;
    assign core_recover = uv.core_supply_low_flag && !pin_s.core_supply_low;

    // wake sources: control edge with io present, bus wake, battery recovery
    assign wake_set = (standby_ctrl_n_rise && !pin_s.io_supply_low) ||
                      (pin_s.wake_event && low_power(mode)) ||
                      bat_recover;
    assign wake_rise = wake_set && !uv_det;

    // mode requested by the accepted control pins
    always_comb begin
        unique case (next_accepted_pins)
            2'h3:    pin_mode = node_mode_pkg::MODE_NORMAL;
            2'h2:    pin_mode = node_mode_pkg::MODE_RX_ONLY;
            2'h1:    pin_mode = node_mode_pkg::MODE_GO_SLEEP;
            default: pin_mode = node_mode_pkg::MODE_STANDBY;
        endcase
    end

    // ----------------------------------------------------------------
    // mode and flags
    // ----------------------------------------------------------------
    node_mode_pkg::mode_t     next_mode;
    logic                     next_wake;
    node_mode_pkg::uv_flags_t next_uv;

    always_comb begin
        next_mode = mode;
        // io/battery edge keeps or forces sleep, even against a recovery
        if (io_rise || bat_rise) begin
            next_mode = node_mode_pkg::MODE_SLEEP;
        end else if (core_rise && !low_power(mode)) begin
            next_mode = node_mode_pkg::MODE_STANDBY;
        end else if (wake_rise && low_power(mode)) begin
            // sleep exits through standby, which then follows the pins
            next_mode = (mode == node_mode_pkg::MODE_SLEEP) ?
                        node_mode_pkg::MODE_STANDBY : pin_mode;
        end else if (mode == node_mode_pkg::MODE_STANDBY && core_recover &&
                     !uv.io_supply_low_flag && !uv.battery_low_flag) begin
            next_mode = pin_mode;
        end else if (mode == node_mode_pkg::MODE_SLEEP && io_recover && !uv.battery_low_flag) begin
            if (pin_s.standby_ctrl_n) begin
                next_mode = pin_mode;
            end
        end else if (uv != '0 || mode == node_mode_pkg::MODE_SLEEP) begin
            next_mode = mode;
        end else if (mode == node_mode_pkg::MODE_GO_SLEEP && hold_done && !wake) begin
            next_mode = node_mode_pkg::MODE_SLEEP;
        end else begin
            next_mode = pin_mode;
        end
    end

    always_comb begin
        next_wake = wake;
        if (uv_det) begin
            next_wake = 1'b0;
        end else if (next_mode == node_mode_pkg::MODE_NORMAL) begin
            next_wake = 1'b0;
        end else if (wake_set) begin
            next_wake = 1'b1;
        end
    end

    // a detection edge wins over any clearing in the same cycle
    always_comb begin
        next_uv = uv;
        if (wake_rise) begin
            next_uv = '0;
        end else begin
            if (io_recover) next_uv.io_supply_low_flag = 1'b0;
            if (bat_recover) next_uv.battery_low_flag = 1'b0;
            if (core_recover) next_uv.core_supply_low_flag = 1'b0;
        end
        if (io_rise) next_uv.io_supply_low_flag = 1'b1;
        if (bat_rise) next_uv.battery_low_flag = 1'b1;
        if (core_rise) next_uv.core_supply_low_flag = 1'b1;
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    node_mode_pkg::pin_out_t out;
    node_mode_pkg::pin_out_t next_out;
    logic                    tx_ok;

    assign tx_ok = pin_s.bus_guard_enable && !pin_s.tx_enable_n && !pin_s.tx_timeout && !pin_s.over_temp;

    always_comb begin
        next_out = node_mode_pkg::RESET_OUT;
        if (!low_power(mode)) begin
            next_out.rx_data      = pin_s.bus_rx_data;
            next_out.rx_active_n  = !pin_s.bus_activity;
            next_out.inhibit_a    = 1'b1;
            next_out.inhibit_a_oe = 1'b1;
            next_out.inhibit_b    = 1'b1;
            next_out.inhibit_b_oe = 1'b1;
            if (mode == node_mode_pkg::MODE_NORMAL && tx_ok) begin
                next_out.bus_drive_en = 1'b1;
                next_out.bus_plus     = pin_s.tx_data;
                next_out.bus_minus    = !pin_s.tx_data;
            end
        end else begin
            // no data path; the pins show the wake flag
            next_out.rx_data      = !wake;
            next_out.rx_active_n  = !wake;
            next_out.inhibit_a    = 1'b1;
            next_out.inhibit_a_oe = (mode != node_mode_pkg::MODE_SLEEP);
            next_out.inhibit_b    = 1'b1;
            next_out.inhibit_b_oe = wake;
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode          <= node_mode_pkg::RESET_MODE;
            wake          <= node_mode_pkg::RESET_WAKE;
            uv            <= node_mode_pkg::RESET_UV;
            out           <= node_mode_pkg::RESET_OUT;
            accepted_pins <= node_mode_pkg::RESET_PINS;
        end else begin
            mode          <= next_mode;
            wake          <= next_wake;
            uv            <= next_uv;
            out           <= next_out;
            accepted_pins <= next_accepted_pins;
        end
    end

    assign mode_o             = mode;
    assign wake_flag_o        = wake;
    assign uv_flags_o         = uv;
    assign rx_data_o          = out.rx_data;
    assign rx_active_n_o      = out.rx_active_n;
    assign inhibit_out_a_o    = out.inhibit_a;
    assign inhibit_out_a_oe_o = out.inhibit_a_oe;
    assign inhibit_out_b_o    = out.inhibit_b;
    assign inhibit_out_b_oe_o = out.inhibit_b_oe;
    assign bus_plus_o         = out.bus_plus;
    assign bus_minus_o        = out.bus_minus;
    assign bus_drive_en_o     = out.bus_drive_en;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_rx_only_txoff: assert property (mode == node_mode_pkg::MODE_RX_ONLY |=> !bus_drive_en_o)
        else $error("transmitter active in receive-only");
    a_inhibit_active: assert property (!low_power(mode) |=>
        inhibit_out_a_o && inhibit_out_a_oe_o && inhibit_out_b_o && inhibit_out_b_oe_o)
        else $error("inhibit not driven high");
    a_sleep_inh_float: assert property (mode == node_mode_pkg::MODE_SLEEP |=> !inhibit_out_a_oe_o)
        else $error("inhibit a driven in sleep");
    a_standby_wake_pins: assert property (mode == node_mode_pkg::MODE_STANDBY && wake |=>
        !rx_active_n_o && !rx_data_o && inhibit_out_b_oe_o && inhibit_out_a_oe_o)
        else $error("standby wake indication wrong");
    a_uv_clears_wake: assert property (uv_det |=> !wake && uv != '0)
        else $error("undervoltage did not clear wake");
    a_wake_clears_uv: assert property ($rose(wake) |-> uv == '0)
        else $error("wake set with undervoltage flag");
    a_uv_forces_sleep: assert property ((io_rise || bat_rise) |=> mode == node_mode_pkg::MODE_SLEEP)
        else $error("undervoltage did not force sleep");
    a_normal_no_wake: assert property (mode == node_mode_pkg::MODE_NORMAL |-> !wake)
        else $error("wake flag set in normal");
    a_tx_data_map: assert property (mode == node_mode_pkg::MODE_NORMAL && tx_ok |=>
        bus_drive_en_o && bus_plus_o == $past(pin_s.tx_data) && bus_minus_o != bus_plus_o)
        else $error("transmit data mapping wrong");
    a_hold_to_sleep: assert property (mode == node_mode_pkg::MODE_GO_SLEEP && hold_done && !wake &&
        !uv_det && !wake_set && uv == '0 |=> mode == node_mode_pkg::MODE_SLEEP)
        else $error("go-to-sleep did not enter sleep");

    c_enter_sleep: cover property (mode == node_mode_pkg::MODE_GO_SLEEP ##1 mode == node_mode_pkg::MODE_SLEEP);
    c_wake_exit: cover property (mode == node_mode_pkg::MODE_SLEEP ##1 mode == node_mode_pkg::MODE_STANDBY);
    c_uv_standby: cover property (core_rise && mode == node_mode_pkg::MODE_NORMAL);
    c_transmit: cover property (bus_drive_en_o);

endmodule

/* pkg/node_mode_pkg.sv */
package node_mode_pkg;

    // ----------------------------------------------------------------
    // operating modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_RX_ONLY,
        MODE_STANDBY,
        MODE_GO_SLEEP,
        MODE_SLEEP
    } mode_t;

    // ----------------------------------------------------------------
    // pin and flag groups
    // ----------------------------------------------------------------
    // asynchronous inputs, synchronised as one vector
    typedef struct packed {
        logic standby_ctrl_n;
        logic mode_sel;
        logic tx_enable_n;
        logic bus_guard_enable;
        logic tx_data;
        logic bus_rx_data;
        logic bus_activity;
        logic wake_event;
        logic io_supply_low;
        logic battery_low;
        logic core_supply_low;
        logic tx_timeout;
        logic over_temp;
    } pin_in_t;

    typedef struct packed {
        logic io_supply_low_flag;
        logic battery_low_flag;
        logic core_supply_low_flag;
    } uv_flags_t;

    // registered pin drive of the device
    typedef struct packed {
        logic rx_data;
        logic rx_active_n;
        logic inhibit_a;
        logic inhibit_a_oe;
        logic inhibit_b;
        logic inhibit_b_oe;
        logic bus_plus;
        logic bus_minus;
        logic bus_drive_en;
    } pin_out_t;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam mode_t     RESET_MODE  = MODE_STANDBY;
    localparam logic      RESET_WAKE  = 1'h0;
    localparam uv_flags_t RESET_UV    = 3'h0;
    localparam pin_out_t  RESET_OUT   = 9'h1f0; // rx high, inhibit a driven high, inhibit b off, bus off
    localparam logic [1:0] RESET_PINS = 2'h0;   // standby code on the control pins

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS         = 10;
    localparam int MODE_PIN_DETECT_NS    = 1000;
    localparam int SLEEP_HOLD_NS         = 20000;
    localparam int TIMER_WIDTH           = 12;
    localparam logic [TIMER_WIDTH-1:0] MODE_PIN_DETECT_CYCLES =
        TIMER_WIDTH'((MODE_PIN_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_WIDTH-1:0] SLEEP_HOLD_CYCLES =
        TIMER_WIDTH'((SLEEP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

/* src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;

    // two flops; the first is read only by the second
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

/* src/mode_timer.sv */
`timescale 1ns/1ps
module mode_timer #(
    parameter logic [node_mode_pkg::TIMER_WIDTH-1:0] TERMINAL = node_mode_pkg::TIMER_WIDTH'(1)
) (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic restart_i,
    output logic      done_o
);

    logic [node_mode_pkg::TIMER_WIDTH-1:0] count;
    logic [node_mode_pkg::TIMER_WIDTH-1:0] next_count;
    logic                                  next_done;

    // saturating up-count, restarted from zero
    always_comb begin
        next_count = count;
        if (restart_i) begin
            next_count = '0;
        end else if (count != TERMINAL) begin
            next_count = count + 1'b1;
        end
        next_done = (next_count == TERMINAL);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count  <= '0;
            done_o <= 1'b0;
        end else begin
            count  <= next_count;
            done_o <= next_done;
        end
    end

endmodule

/* test/host_ctrl_model.sv */
`timescale 1ns/1ps
module host_ctrl_model #(
    parameter int HOLD = int'(node_mode_pkg::MODE_PIN_DETECT_CYCLES) + 4
) (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic [1:0] req_i,
    output logic      [1:0] pins_o
);
    // ----------------------------------------------------------------
    // control pin sequencing, {standby_ctrl_n, mode_sel}
    // ----------------------------------------------------------------
    int wait_cnt;

    // pins move just after the falling edge, like the bench
    always @(negedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins_o   <= node_mode_pkg::RESET_PINS;
            wait_cnt <= 0;
        end else if (req_i == 2'h0 && pins_o == 2'h3) begin
            pins_o[0] <= 1'h0;                    // mode_sel falls first
            wait_cnt  <= 0;
        end else if (req_i == 2'h0 && pins_o == 2'h2) begin
            if (wait_cnt >= HOLD) begin
                pins_o <= req_i;                  // standby low after detect time
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end else begin
            pins_o <= req_i;                      // plain mode code
        end
    end
endmodule

/* test/node_mode_flag_controller_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module node_mode_flag_controller_tb;
    logic                     clk_sys_i;
    logic                     reset_n_i;
    node_mode_pkg::pin_in_t   drv;
    node_mode_pkg::pin_in_t   pins;
    node_mode_pkg::mode_t     mode;
    node_mode_pkg::uv_flags_t uv;
    logic [1:0]               req;
    logic [1:0]               host_pins;
    logic                     wake, rxd, rxa_n, ia, ia_oe, ib, ib_oe, bp, bm, den;
    int                       failures, check_count, cycles;

    // ----------------------------------------------------------------
    // clock, timeout and instances
    // ----------------------------------------------------------------
    initial begin
        clk_sys_i = 1'h0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    // host owns the control pins, bench the rest
    always_comb begin
        pins = drv;
        pins.standby_ctrl_n = host_pins[1];
        pins.mode_sel = host_pins[0];
    end
    host_ctrl_model host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req), .pins_o(host_pins));
    node_mode_flag_controller DUT (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .pins_i(pins), .mode_o(mode),
        .wake_flag_o(wake), .uv_flags_o(uv), .rx_data_o(rxd), .rx_active_n_o(rxa_n),
        .inhibit_out_a_o(ia), .inhibit_out_a_oe_o(ia_oe), .inhibit_out_b_o(ib),
        .inhibit_out_b_oe_o(ib_oe), .bus_plus_o(bp), .bus_minus_o(bm), .bus_drive_en_o(den));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic wait_mode(input node_mode_pkg::mode_t m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) @(negedge clk_sys_i);
        `CHK("mode", m, mode)
        step(2);
    endtask
    task automatic low_power_pins(input logic b_oe, input logic a_oe);
        `CHK("inhibit a oe", a_oe, ia_oe)
        `CHK("inhibit b oe", b_oe, ib_oe)
        `CHK("rx active", ~b_oe, rxa_n)
        `CHK("rx data", ~b_oe, rxd)
        `CHK("drive enable", 1'h0, den)
    endtask
    task automatic end_test(input string n);
        $display("test %s done, mismatches so far %0d", n, failures);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        failures = 0;
        check_count = 0;
        drv = '0;
        req = 2'h0;
        reset_n_i = 1'h0;
        step(20);
        reset_n_i = 1'h1;
        step(2);
        `CHK("reset mode", node_mode_pkg::MODE_STANDBY, mode)
        `CHK("reset wake", 1'h0, wake)
        `CHK("reset uv", 3'h0, uv)
        low_power_pins(1'h0, 1'h1);
        end_test("reset");
        // normal mode and transmitter table
        req = 2'h3;
        wait_mode(node_mode_pkg::MODE_NORMAL, 300);
        `CHK("wake", 1'h0, wake)
        `CHK("inhibit", 4'hf, {ia, ia_oe, ib, ib_oe})
        drv.bus_guard_enable = 1'h1;
        drv.tx_data = 1'h1;
        step(4);
        `CHK("bus", 3'h6, {den, bp, bm})
        `CHK("rx data", 1'h0, rxd)
        drv.tx_data = 1'h0;
        drv.bus_rx_data = 1'h1;
        step(4);
        `CHK("bus", 3'h5, {den, bp, bm})
        `CHK("rx data", 1'h1, rxd)
        drv.tx_enable_n = 1'h1;
        step(4);
        `CHK("enable off", 1'h0, den)
        drv.tx_enable_n = 1'h0;
        drv.bus_guard_enable = 1'h0;
        step(4);
        `CHK("guard off", 1'h0, den)
        drv.bus_guard_enable = 1'h1;
        drv.over_temp = 1'h1;
        drv.bus_activity = 1'h1;
        step(4);
        `CHK("over temp", 1'h0, den)
        `CHK("rx active", 1'h0, rxa_n)
        drv.over_temp = 1'h0;
        drv.bus_activity = 1'h0;
        end_test("normal");
        // receive-only keeps the transmitter off
        req = 2'h2;
        wait_mode(node_mode_pkg::MODE_RX_ONLY, 300);
        `CHK("drive enable", 1'h0, den)
        `CHK("inhibit", 4'hf, {ia, ia_oe, ib, ib_oe})
        end_test("rx_only");
        // normal to standby through the ordered pin drop
        req = 2'h3;
        wait_mode(node_mode_pkg::MODE_NORMAL, 300);
        req = 2'h0;
        wait_mode(node_mode_pkg::MODE_STANDBY, 500);
        low_power_pins(1'h0, 1'h1);
        drv.wake_event = 1'h1;
        step(6);
        drv.wake_event = 1'h0;
        `CHK("wake", 1'h1, wake)
        `CHK("mode", node_mode_pkg::MODE_STANDBY, mode)
        low_power_pins(1'h1, 1'h1);
        `CHK("inhibit b", 1'h1, ib)
        end_test("standby");
        // go-to-sleep hold, sleep, and wake from sleep
        req = 2'h3;
        wait_mode(node_mode_pkg::MODE_NORMAL, 300);
        `CHK("wake", 1'h0, wake)
        req = 2'h1;
        wait_mode(node_mode_pkg::MODE_GO_SLEEP, 300);
        low_power_pins(1'h0, 1'h1);
        wait_mode(node_mode_pkg::MODE_SLEEP, 2200);
        low_power_pins(1'h0, 1'h0);
        drv.wake_event = 1'h1;
        step(6);
        drv.wake_event = 1'h0;
        `CHK("wake", 1'h1, wake)
        wait_mode(node_mode_pkg::MODE_GO_SLEEP, 10);
        end_test("sleep");
        // battery undervoltage and recovery
        req = 2'h3;
        wait_mode(node_mode_pkg::MODE_NORMAL, 300);
        drv.battery_low = 1'h1;
        step(6);
        `CHK("mode", node_mode_pkg::MODE_SLEEP, mode)
        `CHK("uv", 3'h2, uv)
        `CHK("wake", 1'h0, wake)
        drv.battery_low = 1'h0;
        wait_mode(node_mode_pkg::MODE_NORMAL, 300);
        `CHK("uv", 3'h0, uv)
        `CHK("wake", 1'h0, wake)
        end_test("battery");
        // core undervoltage, precedence and recovery
        drv.core_supply_low = 1'h1;
        step(6);
        `CHK("mode", node_mode_pkg::MODE_STANDBY, mode)
        `CHK("uv", 3'h1, uv)
        drv.core_supply_low = 1'h0;
        wait_mode(node_mode_pkg::MODE_NORMAL, 300);
        drv.core_supply_low = 1'h1;
        drv.io_supply_low = 1'h1;
        step(6);
        `CHK("mode", node_mode_pkg::MODE_SLEEP, mode)
        `CHK("uv", 3'h5, uv)
        drv.core_supply_low = 1'h0;
        drv.io_supply_low = 1'h0;
        wait_mode(node_mode_pkg::MODE_NORMAL, 300);
        end_test("core");
        // standby edge during core undervoltage wakes the device
        drv.core_supply_low = 1'h1;
        step(6);
        `CHK("mode", node_mode_pkg::MODE_STANDBY, mode)
        req = 2'h0;
        step(250);
        req = 2'h3;
        wait_mode(node_mode_pkg::MODE_NORMAL, 300);
        `CHK("uv", 3'h0, uv)
        `CHK("wake", 1'h0, wake)
        drv.core_supply_low = 1'h0;
        end_test("uv_wake");
        print_verdict();
    end
endmodule
